// [core/rsdw_device.sv]
// rsdw_device: apb register bank, receive buffer mode/pin directions, fifo delay
// line and transmit dma write channel of the framer end.
// assumes: apb master on clk_i; dma pins arrive from another device (synchronised)
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - modes 00/11 bypass, clock and sync outputs
// RQ2 - mode 01 slip buffer, clock input
// RQ3 - mode 10 fifo with programmable latency
// RQ4 - sync output if select 0, input if 1
// RQ5 - fifo clock must match recovered line clock
// RQ6 - delay data by 5-bit latency, reset 4
// RQ7 - latency used only in fifo mode
// RQ8 - dma reset on zero-to-one bit transition
// RQ9 - dma interface active only while enabled
// RQ10 - request only when buffer has message room
// RQ11 - dma words go into transmit buffer
// RQ12 - cycle starts with request driven low
// RQ13 - controller answers request with acknowledge low
// RQ14 - strobe mode: word on each write strobe
// RQ15 - direction mode: word on each read strobe
// RQ16 - write type picks strobe or direction pin
// RQ17 - reset drops request, abandons partial transfer
module rsdw_device #(
  parameter int MSG_WORDS = 4,
  parameter int BUF_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // receive serial side
  input  wire logic        rx_data_i,
  output logic             rx_data_o,
  output logic             rx_serial_clock_oe_o,
  output logic             rx_frame_sync_oe_o,
  // transmit buffer drain side
  input  wire logic        tx_pop_i,
  output logic      [7:0]  tx_word_o,
  output logic             tx_word_valid_o,
  // dma pins
  rsdw_dma_if.dev          dma
);
  typedef enum logic [1:0] {RSDW_IDLE, RSDW_REQ, RSDW_XFER} rsdw_state_type;

  logic [7:0] sbc, lat, dmaw;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH):0] count;
  logic [$clog2(BUF_DEPTH)-1:0] wptr, rptr;
  logic [$clog2(MSG_WORDS+1)-1:0] words;
  logic [31:0] dline;
  logic [7:0] data_s1, data_s2;
  logic [2:0] ack_s1, ack_s2, ack_d;  // ack, wr, rd
  logic rst_seen;
  rsdw_state_type state, next_state;

  // apb decode; zero-wait answers, unmapped reads as zero with error
  wire acc     = psel_i & penable_i;
  wire wr_en   = acc & pwrite_i & ce_i;
  wire hit_sbc = paddr_i == rsdw_pkg::SBC_ADDR;
  wire hit_lat = paddr_i == rsdw_pkg::LAT_ADDR;
  wire hit_dma = paddr_i == rsdw_pkg::DMAW_ADDR;
  wire hit_st  = paddr_i == rsdw_pkg::STAT_ADDR;
  wire mapped  = hit_sbc | hit_lat | hit_dma | hit_st;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  // mode decode
  wire [1:0] mode     = sbc[rsdw_pkg::MODE_LSB +: 2];
  wire       bypass   = mode == rsdw_pkg::MODE_BYP0 || mode == rsdw_pkg::MODE_BYP3;
  wire       fifo_md  = mode == rsdw_pkg::MODE_FIFO;
  wire       sdir_in  = sbc[rsdw_pkg::SDIR_BIT];
  assign rx_serial_clock_oe_o = bypass;              // RQ1 RQ2 RQ3
  assign rx_frame_sync_oe_o   = bypass | ~sdir_in;   // RQ1 RQ4

  // dma control decode
  wire dma_en   = dmaw[rsdw_pkg::DENB_BIT];
  wire wtype    = dmaw[rsdw_pkg::WTYPE_BIT];
  wire next_rst = wr_en & hit_dma & pwdata_i[rsdw_pkg::DRST_BIT];
  wire rst_edge = next_rst & ~dmaw[rsdw_pkg::DRST_BIT];  // RQ8
  wire room     = (BUF_DEPTH - int'(count)) >= MSG_WORDS;

  // synchronised controller pins; logic uses the second stage and its one-cycle delayed copy (ack_d)
  wire ack_low  = ~ack_s2[0];
  wire strobe_f = wtype ? (ack_d[1] & ~ack_s2[1])       // RQ16 RQ14
                        : (ack_d[2] & ~ack_s2[2] & ~ack_s2[1]); // RQ15
  wire take     = (state == RSDW_XFER) & ack_low & strobe_f & (count < BUF_DEPTH);

  // register bank
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sbc  <= rsdw_pkg::SBC_RESET;
      lat  <= rsdw_pkg::LAT_RESET;
      dmaw <= rsdw_pkg::DMAW_RESET;
    end else if (wr_en) begin
      if (hit_sbc) sbc <= pwdata_i[7:0] & 8'h9f;
      if (hit_lat) lat <= pwdata_i[7:0] & 8'h1f;
      if (hit_dma) dmaw <= pwdata_i[7:0] & 8'he0;
    end
  end

  // read mux from flip-flops for stable data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) prdata_o <= 32'h0;
    else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= hit_sbc ? {24'h0, sbc} :
                  hit_lat ? {24'h0, lat} :
                  hit_dma ? {24'h0, dmaw} :
                  hit_st  ? {16'h0, 3'h0, count[4:0], 5'h0, rst_seen, state} : 32'h0;
    end
  end

  // receive delay line; bypass/slip pass straight through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dline     <= 32'h0;
      rx_data_o <= 1'b0;
    end else if (ce_i) begin
      dline     <= {dline[30:0], rx_data_i};
      // latency 0 degenerates to two register stages
      rx_data_o <= fifo_md ? dline[lat[4:0]] : rx_data_i;  // RQ6 RQ7 RQ3 RQ5
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1 <= 3'h7;
      ack_s2 <= 3'h7;
      ack_d  <= 3'h7;
      data_s1 <= 8'h0;
      data_s2 <= 8'h0;
    end else if (ce_i) begin
      ack_s1 <= {dma.rd_n, dma.wr_n, dma.dma_write_acknowledge_n};
      ack_s2 <= ack_s1;
      ack_d  <= ack_s2;
      data_s1 <= dma.data;
      data_s2 <= data_s1;
    end
  end

  // request state machine
  always_comb begin
    next_state = state;
    case (state)
      RSDW_IDLE: if (dma_en && room) next_state = RSDW_REQ;  // RQ9 RQ10
      RSDW_REQ:  if (!dma_en) next_state = RSDW_IDLE;
                 else if (ack_low) next_state = RSDW_XFER;   // RQ13
      RSDW_XFER: if (!dma_en || (take && words == MSG_WORDS - 1)) next_state = RSDW_IDLE;
      default:   next_state = RSDW_IDLE;
    endcase
    if (rst_edge) next_state = RSDW_IDLE;  // RQ17
  end
  assign dma.dma_write_request_n = ~(state != RSDW_IDLE);  // RQ12

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= RSDW_IDLE;
      words    <= '0;
      rst_seen <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      if (rst_edge || next_state == RSDW_IDLE) words <= '0;  // RQ17
      else if (take) words <= words + 1'b1;
      if (rst_edge) rst_seen <= 1'b1;
    end
  end

  // transmit message buffer
  assign tx_word_valid_o = count != 0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      tx_word_o <= 8'h0;
    end else if (ce_i) begin
      if (rst_edge) begin  // RQ8
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (take) begin
          buf_mem[wptr] <= data_s2;  // RQ11
          wptr <= wptr + 1'b1;
        end
        if (tx_pop_i && count != 0) rptr <= rptr + 1'b1;
        count <= count + (take ? 1'b1 : 1'b0) - ((tx_pop_i && count != 0) ? 1'b1 : 1'b0);
      end
      tx_word_o <= buf_mem[rptr];
    end
  end
endmodule
`default_nettype wire

// [core/rsdw_pkg.sv]
// rsdw_pkg: shared constants for the receive buffer / dma write config block
// assumes: one 200 MHz clock, registers on word-aligned apb offsets
package rsdw_pkg;
  // register byte addresses (latency has a printed index; others chosen here)
  localparam logic [11:0] LAT_IDX        = 12'h117;
  localparam logic [11:0] LAT_ADDR       = 12'h45c;   // 4 * index
  localparam logic [11:0] SBC_ADDR       = 12'h000;
  localparam logic [11:0] DMAW_ADDR      = 12'h004;
  localparam logic [11:0] STAT_ADDR      = 12'h008;
  // field positions
  localparam int MODE_LSB   = 0;
  localparam int SDIR_BIT   = 2;
  localparam int WTYPE_BIT  = 5;
  localparam int DENB_BIT   = 6;
  localparam int DRST_BIT   = 7;
  // reset values
  localparam logic [7:0] SBC_RESET  = 8'h05;  // mode 01, sync direction input
  localparam logic [7:0] LAT_RESET  = 8'h04;  // latency 00100
  localparam logic [7:0] DMAW_RESET = 8'h00;
  // buffer modes
  localparam logic [1:0] MODE_BYP0 = 2'h0;
  localparam logic [1:0] MODE_SLIP = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [1:0] MODE_BYP3 = 2'h3;
  localparam int LAT_W = 5;
endpackage

// [core/rsdw_dma_if.sv]
// rsdw_dma_if: dma write channel pins between the framer end and the dma controller
// assumes: both ends on the same clock; the bench resolves shared pins
`timescale 1ns/1ps
`default_nettype none
interface rsdw_dma_if;
  logic       dma_write_request_n;
  logic       dma_write_acknowledge_n;
  logic       wr_n;   // write strobe or direction
  logic       rd_n;   // data strobe in direction mode
  logic [7:0] data;
  modport dev (output dma_write_request_n, input dma_write_acknowledge_n, input wr_n, input rd_n, input data);
  modport ctl (input dma_write_request_n, output dma_write_acknowledge_n, output wr_n, output rd_n, output data);
endinterface
`default_nettype wire

// [core/rsdw_dma_ctl.sv]
// rsdw_dma_ctl: dma controller end; answers requests and strobes words out
// assumes: same clock as the framer end; words come from a user valid/ready port
`timescale 1ns/1ps
`default_nettype none
module rsdw_dma_ctl (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       strobe_mode_i,
  input  wire logic [7:0] word_i,
  input  wire logic       word_valid_i,
  output logic            word_ready_o,
  rsdw_dma_if.ctl         dma
);
  typedef enum logic [1:0] {RSDWC_IDLE, RSDWC_SET, RSDWC_LOW, RSDWC_HIGH} rsdwc_state_type;
  rsdwc_state_type state;
  logic [1:0] hold;
  logic       ack_n, strb_n;
  logic [7:0] data;
  logic [1:0] req_s;

  // strobe lows last long enough for the framer's two-stage sync
  assign dma.dma_write_acknowledge_n = ack_n;     // RQ13
  assign dma.wr_n = strobe_mode_i ? strb_n : ack_n;  // RQ14 RQ16 direction: write only while acknowledged
  assign dma.rd_n = strobe_mode_i ? 1'b1 : strb_n;  // RQ15
  assign dma.data = data;
  assign word_ready_o = state == RSDWC_IDLE && !req_s[1] && !ack_n;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_s <= 2'h3;
      state <= RSDWC_IDLE;
      hold  <= 2'h0;
      ack_n <= 1'b1;
      strb_n <= 1'b1;
      data  <= 8'h0;
    end else if (ce_i) begin
      req_s <= {req_s[0], dma.dma_write_request_n};
      hold  <= hold + 1'b1;
      case (state)
        RSDWC_IDLE: begin
          ack_n <= req_s[1];
          if (!req_s[1] && !ack_n && word_valid_i) begin
            data  <= word_i;  // RQ14 RQ15
            state <= RSDWC_SET;
            hold  <= 2'h0;
          end
        end
        RSDWC_SET: if (hold == 2'h3) begin
          strb_n <= 1'b0;
          state  <= RSDWC_LOW;
          hold   <= 2'h0;
        end
        RSDWC_LOW: if (hold == 2'h3) begin
          strb_n <= 1'b1;
          state  <= RSDWC_HIGH;
          hold   <= 2'h0;
        end
        RSDWC_HIGH: if (hold == 2'h3) state <= RSDWC_IDLE;
        default: state <= RSDWC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/rsdw_checker.sv]
// rsdw_checker: pin checks on the dma write link between both ends
// assumes: both ends on clk_i; sees the shared interface only
`timescale 1ns/1ps
`default_nettype none
module rsdw_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       dma_write_request_n,
  input wire logic       dma_write_acknowledge_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] data
);
  // short aliases keep each property on one line
  wire rq = dma_write_request_n;
  wire ak = dma_write_acknowledge_n;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_req; $fell(ak) |-> !rq; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_ack_soon; $fell(rq) |-> ##[0:40] !ak; endproperty
  a_ack_soon: assert property (p_ack_soon) else $error("request unanswered");
  property p_req_holds; $fell(rq) |=> (!rq)[*3]; endproperty
  a_req_holds: assert property (p_req_holds) else $error("request dropped early");
  property p_idle; $fell(rst_i) |-> rq && ak; endproperty
  a_idle: assert property (p_idle) else $error("link busy after reset");
  property p_wr_xfer; $fell(wr_n) |-> !rq; endproperty
  a_wr_xfer: assert property (p_wr_xfer) else $error("write strobe idle");
  property p_rd_xfer; $fell(rd_n) |-> !ak && !wr_n; endproperty
  a_rd_xfer: assert property (p_rd_xfer) else $error("read strobe idle");
  property p_wr_gap; $fell(wr_n) |=> (!$fell(wr_n))[*8]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write strobes close");
  property p_rd_gap; $fell(rd_n) |=> (!$fell(rd_n))[*8]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read strobes close");
  property p_data_hold; !rd_n |-> $stable(data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved under read strobe");
endmodule
`default_nettype wire

// [verif/tb.sv]
// tb: framer end and dma controller end on one link
// assumes: package, interface, both ends and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rxd = 1'b0;
  logic        ce = 1'b1, pop = 1'b0, smode = 1'b0, wv = 1'b0, pready, pse, se, rxq, sck_oe, fs_oe, txv, wrdy;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  txw, wd = 8'h00;
  int          err_count, n_tests, d [4];
  rsdw_dma_if  dma ();
  rsdw_device u_rsdw_device (.clk_i, .rst_i, .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pse), .rx_data_i(rxd),
    .rx_data_o(rxq), .rx_serial_clock_oe_o(sck_oe), .rx_frame_sync_oe_o(fs_oe), .tx_pop_i(pop), .tx_word_o(txw),
    .tx_word_valid_o(txv), .dma(dma.dev));
  rsdw_dma_ctl u_rsdw_dma_ctl (.clk_i, .rst_i, .ce_i(ce), .strobe_mode_i(smode), .word_i(wd),
    .word_valid_i(wv), .word_ready_o(wrdy), .dma(dma.ctl));
  rsdw_checker u_rsdw_checker (.clk_i, .rst_i, .dma_write_request_n(dma.dma_write_request_n),
    .dma_write_acknowledge_n(dma.dma_write_acknowledge_n), .wr_n(dma.wr_n), .rd_n(dma.rd_n), .data(dma.data));
  // clock, and a run limit far above the several hundred cycles needed
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("unexpected run_limit exp done got hang");
    err_count++;
    final_report();
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_i);
    penable <= 1'b1;
    // answer taken at the edge that ends the access, then released
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    se = pse;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(input logic [7:0] w);
    @(posedge clk_i);
    wd <= w;
    wv <= 1'b1;
    do @(posedge clk_i); while (wrdy !== 1'b1);
    wv <= 1'b0;
  endtask
  task automatic t_regs;
    logic [11:0] ra [3] = '{rsdw_pkg::SBC_ADDR, rsdw_pkg::LAT_ADDR, rsdw_pkg::DMAW_ADDR};
    logic [7:0]  rv [3] = '{8'h05, 8'h04, 8'h00};
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_value", {24'h0, rv[i]}, {24'h0, rd[7:0]});
    end
    apb(1'b1, 12'h00c, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, rsdw_pkg::SBC_ADDR, 32'(m));
      // the write lands at the access edge; look once it has settled
      @(negedge clk_i);
      chk("pin_dirs", {30'h0, m[1] ~^ m[0], (m[1] ~^ m[0]) | ~m[2]}, {30'h0, sck_oe, fs_oe});
    end
    // clock enable low: a write must not land
    @(posedge clk_i);
    ce <= 1'b0;
    apb(1'b1, rsdw_pkg::SBC_ADDR, 32'h6);
    @(posedge clk_i);
    ce <= 1'b1;
    apb(1'b0, rsdw_pkg::SBC_ADDR, 32'h0);
    chk("ce_freeze", 32'h7, rd);
    $display("t_regs done");
  endtask
  task automatic t_lat;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, rsdw_pkg::SBC_ADDR, k < 2 ? 32'h6 : 32'h5);
      apb(1'b1, rsdw_pkg::LAT_ADDR, k[0] ? 32'h9 : 32'h4);
      @(posedge clk_i);
      rxd <= 1'b1;
      @(posedge clk_i);
      rxd <= 1'b0;
      d[k] = 0;
      do @(negedge clk_i); while (rxq !== 1'b1 && ++d[k] < 64);
    end
    chk("fifo_step", 32'h5, 32'(d[1] - d[0]));
    chk("slip_step", 32'h0, 32'(d[3] - d[2]));
    chk("slip_delay", 32'h0, 32'(d[2]));
    $display("t_lat done");
  endtask
  task automatic t_dma(input logic ty);
    @(posedge clk_i);
    smode <= ty;
    apb(1'b1, rsdw_pkg::DMAW_ADDR, {26'h1, ty, 5'h0});
    for (int i = 0; i < 16; i++) put({ty, 7'h0} + 8'(i));
    do apb(1'b0, rsdw_pkg::STAT_ADDR, 32'h0); while (rd[12:8] !== 5'h10);
    chk("req_full", 32'h1, {31'h0, dma.dma_write_request_n});
    apb(1'b1, rsdw_pkg::DMAW_ADDR, 32'h0);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      chk("tx_word", {24'h0, {ty, 7'h0} + 8'(i)}, {24'h0, txw});
      @(posedge clk_i);
      pop <= 1'b1;
      @(posedge clk_i);
      pop <= 1'b0;
      // head word register lags the read pointer by one edge
      @(posedge clk_i);
    end
    @(negedge clk_i);
    chk("req_off", 32'h1, {30'h0, txv, dma.dma_write_request_n});
    $display("t_dma done");
  endtask
  task automatic t_drst;
    apb(1'b1, rsdw_pkg::DMAW_ADDR, 32'h60);
    for (int i = 0; i < 2; i++) put(8'h11);
    do apb(1'b0, rsdw_pkg::STAT_ADDR, 32'h0); while (rd[12:8] !== 5'h2);
    apb(1'b1, rsdw_pkg::DMAW_ADDR, 32'he0);
    apb(1'b0, rsdw_pkg::STAT_ADDR, 32'h0);
    chk("flushed", 32'h4, {19'h0, rd[12:8], 5'h0, rd[2], 2'h0});
    $display("t_drst done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset for three cycles, then every scenario in turn
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_lat();
    t_dma(1'b1);
    t_dma(1'b0);
    @(posedge clk_i);
    smode <= 1'b1;
    t_drst();
    final_report();
  end
endmodule
`default_nettype wire
